// [src/aasi_defs.vh]
`ifndef AASI_DEFS_VH
`define AASI_DEFS_VH
// Address space codes carried with every request.
`define AASI_SP_IO      2'h0
`define AASI_SP_MEM     2'h1
`define AASI_SP_MSG     2'h2
// Transfer width codes: number of bytes minus one.
`define AASI_W_1B       2'h0
`define AASI_W_2B       2'h1
`define AASI_STEP_1B    32'h0000_0001
`define AASI_STEP_2B    32'h0000_0002
`define AASI_STEP_4B    32'h0000_0004
// Local extension bus address width and the selector's region split.
`define AASI_LBX_AW     26
`define AASI_HI_MSB     31
`define AASI_HI_LSB     26
`define AASI_HI_LBX     6'h00
`define AASI_IO_AW      16
// Message header layout (word 0: dest, src; word 1: type, type specific).
`define AASI_DEST_MSB   7
`define AASI_DEST_LSB   0
`define AASI_SRC_MSB    15
`define AASI_SRC_LSB    8
`define AASI_TYPE_MSB   7
`define AASI_TYPE_LSB   0
`define AASI_BCAST      8'hFF
`define AASI_MSG_TYPES  8'h06
`define AASI_MSG_MAXW   4'h8
`define AASI_CNT_ONE    4'h1
// Message FIFO shape: {err, last, data[31:0]}.
`define AASI_FIFO_W     34
`define AASI_FIFO_D     32
`define AASI_FIFO_AW    5
// Replying state machine, one-hot.
`define AASI_ST_IDLE    3'h1
`define AASI_ST_BUSY    3'h2
`define AASI_ST_ACK     3'h4
`endif

// [src/aasi_agent.v]
`include "aasi_defs.vh"
`default_nettype none

module aasi_fifo #(
  parameter W  = `AASI_FIFO_W,
  parameter D  = `AASI_FIFO_D,
  parameter AW = `AASI_FIFO_AW
) (
  input  wire          core_clk,   // Clock.
  input  wire          rst_b,      // Asynchronous reset, active low.
  input  wire          in_valid,   // Write word offered.
  output wire          in_ready,   // Room for a word.
  input  wire [W-1:0]  in_data,    // Word written.
  output wire          out_valid,  // Word available.
  input  wire          out_ready,  // Consumer takes the word.
  output wire [W-1:0]  out_data    // Oldest word.
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0]   count_reg;
  wire         push;
  wire         pop;

  assign in_ready  = (count_reg != D[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

module aasi_agent (
  input  wire        core_clk,       // 125 MHz clock.
  input  wire        rst_b,          // Asynchronous reset, active low.
  input  wire        req_valid,      // Initiator request offered.
  output wire        req_ready,      // Request taken.
  input  wire [1:0]  req_space,      // Address space.
  input  wire        req_write,      // Write when high.
  input  wire [31:0] req_addr,       // Request address.
  input  wire [1:0]  req_width,      // Bytes minus one.
  input  wire [31:0] req_wdata,      // Write data or packet word.
  input  wire        req_last,       // Last transfer of a sequence.
  output reg         req_rsp_valid,  // Read data pulse.
  output reg  [31:0] req_rdata,      // Read data.
  output wire        psb_out_valid,  // Parallel bus request.
  input  wire        psb_out_ready,  // Parallel bus completion.
  output wire [1:0]  psb_out_space,  // Space code.
  output wire        psb_out_write,  // Write when high.
  output wire [31:0] psb_out_addr,   // Address.
  output wire [1:0]  psb_out_width,  // Bytes minus one.
  output wire [31:0] psb_out_data,   // Write data.
  output wire [3:0]  psb_out_par,    // Even byte parity of data.
  output wire        psb_out_last,   // Last transfer.
  input  wire [31:0] psb_out_rdata,  // Read data returned.
  output wire        lbx_out_valid,  // Extension bus request.
  input  wire        lbx_out_ready,  // Extension bus completion.
  output wire        lbx_out_write,  // Write when high.
  output wire [25:0] lbx_out_addr,   // Address.
  output wire [1:0]  lbx_out_width,  // Bytes minus one.
  output wire [31:0] lbx_out_data,   // Write data.
  output wire        lbx_out_last,   // Last transfer.
  input  wire [31:0] lbx_out_rdata,  // Read data returned.
  input  wire        psb_in_valid,   // Parallel bus transfer seen.
  output wire        psb_in_ready,   // Handshake completion.
  input  wire [1:0]  psb_in_space,   // Space code.
  input  wire        psb_in_write,   // Write when high.
  input  wire        psb_in_first,   // Fresh address (sequence start).
  input  wire        psb_in_last,    // Last word of a packet.
  input  wire [31:0] psb_in_addr,    // Address.
  input  wire [1:0]  psb_in_width,   // Bytes minus one.
  input  wire [31:0] psb_in_data,    // Write data or packet word.
  input  wire [3:0]  psb_in_par,     // Even byte parity.
  output reg  [31:0] psb_in_rdata,   // Read data, valid with ready.
  input  wire        lbx_in_valid,   // Extension bus transfer seen.
  output wire        lbx_in_ready,   // Handshake completion.
  input  wire        lbx_in_write,   // Write when high.
  input  wire        lbx_in_first,   // Fresh address.
  input  wire [25:0] lbx_in_addr,    // Address.
  input  wire [1:0]  lbx_in_width,   // Bytes minus one.
  input  wire [31:0] lbx_in_data,    // Write data.
  output reg  [31:0] lbx_in_rdata,   // Read data, valid with ready.
  input  wire [15:0] io_base,        // Own I/O address.
  input  wire [15:0] io_mask,        // I/O bits compared.
  input  wire [31:0] psb_mem_base,   // Own parallel memory window.
  input  wire [31:0] psb_mem_mask,   // Parallel bits compared.
  input  wire [25:0] lbx_mem_base,   // Own extension memory window.
  input  wire [25:0] lbx_mem_mask,   // Extension bits compared.
  input  wire [7:0]  my_msg_addr,    // Own message address.
  output reg         rcv_valid,      // Receiver operation pending.
  input  wire        rcv_ready,      // Receiver done.
  output reg  [1:0]  rcv_space,      // Space of operation.
  output reg         rcv_write,      // Write when high.
  output reg  [31:0] rcv_addr,       // Operation address.
  output reg  [1:0]  rcv_width,      // Bytes minus one.
  output reg  [31:0] rcv_wdata,      // Write data.
  input  wire [31:0] rcv_rdata,      // Read data from receiver.
  output wire        msg_valid,      // Packet word available.
  input  wire        msg_ready,      // Consumer takes the word.
  output wire [31:0] msg_data,       // Packet word.
  output wire        msg_last,       // Last word of packet.
  output wire        msg_err         // Word had bad parity or type.
);
  reg        ob_valid_reg;
  reg        ob_lbx_reg;
  reg [1:0]  ob_space_reg;
  reg        ob_write_reg;
  reg [31:0] ob_addr_reg;
  reg [1:0]  ob_width_reg;
  reg [31:0] ob_data_reg;
  reg        ob_last_reg;
  reg [2:0]  st_reg;
  reg        gnt_lbx_reg;
  reg        prio_lbx_reg;
  reg [31:0] psb_seq_reg;
  reg [25:0] lbx_seq_reg;
  reg        m_first_reg;
  reg        m_keep_reg;
  reg        m_bc_reg;
  reg [3:0]  m_cnt_reg;
  wire       out_done;
  wire       to_lbx;
  wire       psb_hit;
  wire       lbx_hit;
  wire       pick_lbx;
  wire [3:0] par_bad;
  wire       is_msg;
  wire       hdr_ok;
  wire       keep_now;
  wire       bc_now;
  wire       type_bad;
  wire       msg_take;
  wire       fifo_in_ready;
  wire [`AASI_FIFO_W-1:0] fifo_out;
  reg  [31:0] step;
  wire [31:0] rcv_addr_next;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_par
      assign psb_out_par[g] = ^ob_data_reg[8*g+7:8*g];
      assign par_bad[g]     = (^psb_in_data[8*g+7:8*g]) ^ psb_in_par[g];
    end
  endgenerate

  // Requesting side: memory below the extension region boundary goes to the extension bus.
  assign to_lbx    = (req_space == `AASI_SP_MEM) &&
                     (req_addr[`AASI_HI_MSB:`AASI_HI_LSB] == `AASI_HI_LBX);
  assign out_done  = ob_valid_reg & (ob_lbx_reg ? lbx_out_ready : psb_out_ready);
  assign req_ready = ~ob_valid_reg | out_done;

  assign psb_out_valid = ob_valid_reg & ~ob_lbx_reg;
  assign psb_out_space = ob_space_reg;
  assign psb_out_write = ob_write_reg;
  assign psb_out_addr  = ob_addr_reg;
  assign psb_out_width = ob_width_reg;
  assign psb_out_data  = ob_data_reg;
  assign psb_out_last  = ob_last_reg;
  assign lbx_out_valid = ob_valid_reg & ob_lbx_reg;
  assign lbx_out_write = ob_write_reg;
  assign lbx_out_addr  = ob_addr_reg[`AASI_LBX_AW-1:0];
  assign lbx_out_width = ob_width_reg;
  assign lbx_out_data  = ob_data_reg;
  assign lbx_out_last  = ob_last_reg;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ob_valid_reg  <= 1'b0;
      ob_lbx_reg    <= 1'b0;
      ob_space_reg  <= `AASI_SP_IO;
      ob_write_reg  <= 1'b0;
      ob_addr_reg   <= 32'h0000_0000;
      ob_width_reg  <= `AASI_W_1B;
      ob_data_reg   <= 32'h0000_0000;
      ob_last_reg   <= 1'b0;
      req_rsp_valid <= 1'b0;
      req_rdata     <= 32'h0000_0000;
    end else begin
      req_rsp_valid <= out_done & ~ob_write_reg;
      if (out_done & ~ob_write_reg) begin
        req_rdata <= ob_lbx_reg ? lbx_out_rdata : psb_out_rdata;
      end
      if (req_valid & req_ready) begin
        // A message read is swallowed: message space carries writes only.
        ob_valid_reg <= ~((req_space == `AASI_SP_MSG) & ~req_write);
        ob_lbx_reg   <= to_lbx;
        ob_space_reg <= req_space;
        ob_write_reg <= req_write;
        ob_addr_reg  <= req_addr;
        ob_width_reg <= req_width;
        ob_data_reg  <= req_wdata;
        ob_last_reg  <= req_last;
      end else if (out_done) begin
        ob_valid_reg <= 1'b0;
      end
    end
  end

  // Replying side: address match on both buses at once.
  assign psb_hit = psb_in_valid & (((psb_in_space == `AASI_SP_IO) &
                   ((psb_in_addr[`AASI_IO_AW-1:0] & io_mask) == io_base)) |
                   ((psb_in_space == `AASI_SP_MEM) &
                   ((psb_in_addr & psb_mem_mask) == psb_mem_base)));
  assign lbx_hit = lbx_in_valid & ((lbx_in_addr & lbx_mem_mask) == lbx_mem_base);
  assign pick_lbx = lbx_hit & (~psb_hit | prio_lbx_reg);

  always @* begin
    case (rcv_width)
      `AASI_W_1B: step = `AASI_STEP_1B;
      `AASI_W_2B: step = `AASI_STEP_2B;
      default:    step = `AASI_STEP_4B;
    endcase
  end
  // I/O sequences stay on one address; memory sequences advance by width.
  assign rcv_addr_next = (rcv_space == `AASI_SP_IO) ? rcv_addr : rcv_addr + step;

  // The loser sees no ready until it is served.
  assign psb_in_ready = ((st_reg == `AASI_ST_ACK) & ~gnt_lbx_reg) | msg_take;
  assign lbx_in_ready = (st_reg == `AASI_ST_ACK) & gnt_lbx_reg;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg       <= `AASI_ST_IDLE;
      gnt_lbx_reg  <= 1'b0;
      prio_lbx_reg <= 1'b0;
      psb_seq_reg  <= 32'h0000_0000;
      lbx_seq_reg  <= 26'h000_0000;
      rcv_valid    <= 1'b0;
      rcv_space    <= `AASI_SP_IO;
      rcv_write    <= 1'b0;
      rcv_addr     <= 32'h0000_0000;
      rcv_width    <= `AASI_W_1B;
      rcv_wdata    <= 32'h0000_0000;
      psb_in_rdata <= 32'h0000_0000;
      lbx_in_rdata <= 32'h0000_0000;
    end else begin
      case (st_reg)
        `AASI_ST_IDLE: begin
          if (psb_hit | lbx_hit) begin
            st_reg      <= `AASI_ST_BUSY;
            gnt_lbx_reg <= pick_lbx;
            rcv_valid   <= 1'b1;
            if (pick_lbx) begin
              rcv_space <= `AASI_SP_MEM;
              rcv_write <= lbx_in_write;
              rcv_width <= lbx_in_width;
              rcv_wdata <= lbx_in_data;
              rcv_addr  <= {6'h00, (lbx_in_first ? lbx_in_addr : lbx_seq_reg)};
            end else begin
              rcv_space <= psb_in_space;
              rcv_write <= psb_in_write;
              rcv_width <= psb_in_width;
              rcv_wdata <= psb_in_data;
              rcv_addr  <= psb_in_first ? psb_in_addr : psb_seq_reg;
            end
          end
        end
        `AASI_ST_BUSY: begin
          if (rcv_ready) begin
            st_reg    <= `AASI_ST_ACK;
            rcv_valid <= 1'b0;
            if (gnt_lbx_reg) begin
              lbx_in_rdata <= rcv_rdata;
            end else begin
              psb_in_rdata <= rcv_rdata;
            end
          end
        end
        `AASI_ST_ACK: begin
          st_reg       <= `AASI_ST_IDLE;
          prio_lbx_reg <= ~gnt_lbx_reg;
          if (gnt_lbx_reg) begin
            lbx_seq_reg <= rcv_addr_next[`AASI_LBX_AW-1:0];
          end else begin
            psb_seq_reg <= rcv_addr_next;
          end
        end
        default: begin
          st_reg    <= `AASI_ST_IDLE;
          rcv_valid <= 1'b0;
        end
      endcase
    end
  end

  // Message receive: header checked on word 0, type on word 1.
  assign is_msg   = psb_in_valid & (psb_in_space == `AASI_SP_MSG);
  assign hdr_ok   = psb_in_write &
                    ((psb_in_data[`AASI_DEST_MSB:`AASI_DEST_LSB] == my_msg_addr) |
                     (psb_in_data[`AASI_DEST_MSB:`AASI_DEST_LSB] == `AASI_BCAST)) &
                    (psb_in_data[`AASI_SRC_MSB:`AASI_SRC_LSB] != `AASI_BCAST);
  assign keep_now = m_first_reg ? hdr_ok : (m_keep_reg & (m_cnt_reg < `AASI_MSG_MAXW));
  assign bc_now   = m_first_reg ? (psb_in_data[`AASI_DEST_MSB:`AASI_DEST_LSB] == `AASI_BCAST) : m_bc_reg;
  // Type specific byte is passed on but never inspected.
  assign type_bad = ~m_first_reg & (m_cnt_reg == `AASI_CNT_ONE) &
                    (psb_in_data[`AASI_TYPE_MSB:`AASI_TYPE_LSB] >= `AASI_MSG_TYPES);
  // Broadcast words never stall; when the buffer is full they are lost.
  assign msg_take = is_msg & (fifo_in_ready | ~keep_now | bc_now);

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      m_first_reg <= 1'b1;
      m_keep_reg  <= 1'b0;
      m_bc_reg    <= 1'b0;
      m_cnt_reg   <= 4'h0;
    end else if (msg_take) begin
      m_first_reg <= psb_in_last;
      m_cnt_reg   <= m_first_reg ? `AASI_CNT_ONE : m_cnt_reg + `AASI_CNT_ONE;
      m_keep_reg  <= keep_now & ~type_bad;
      m_bc_reg    <= bc_now;
    end
  end

  aasi_fifo #(
    .W  (`AASI_FIFO_W),
    .D  (`AASI_FIFO_D),
    .AW (`AASI_FIFO_AW)
  ) u_msg_fifo (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .in_valid  (msg_take & keep_now),
    .in_ready  (fifo_in_ready),
    .in_data   ({(|par_bad) | type_bad, psb_in_last, psb_in_data}),
    .out_valid (msg_valid),
    .out_ready (msg_ready),
    .out_data  (fifo_out)
  );

  assign msg_data = fifo_out[31:0];
  assign msg_last = fifo_out[32];
  assign msg_err  = fifo_out[33];
endmodule

`default_nettype wire

// [dv/aasi_agent_sva.sv]
`default_nettype none
module aasi_agent_sva (
  input wire logic        core_clk,      // Clock.
  input wire logic        rst_b,         // Reset.
  input wire logic        req_valid,     // Request.
  input wire logic        req_ready,     // Taken.
  input wire logic [1:0]  req_space,     // Space.
  input wire logic [31:0] req_addr,      // Address.
  input wire logic        req_rsp_valid, // Read done.
  input wire logic [31:0] req_rdata,     // Read data.
  input wire logic        psb_out_valid, // Out request.
  input wire logic        psb_out_ready, // Out done.
  input wire logic        psb_out_write, // Write.
  input wire logic [31:0] psb_out_addr,  // Address.
  input wire logic [31:0] psb_out_data,  // Data.
  input wire logic [3:0]  psb_out_par,   // Parity.
  input wire logic [31:0] psb_out_rdata, // Read data.
  input wire logic        lbx_out_valid, // Out request.
  input wire logic [25:0] lbx_out_addr,  // Address.
  input wire logic        psb_in_ready,  // Handshake.
  input wire logic [1:0]  psb_in_space,  // Space.
  input wire logic        lbx_in_ready,  // Handshake.
  input wire logic        rcv_valid,     // Receiver request.
  input wire logic        rcv_ready      // Receiver done.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_io_psb_only: assert property (
    req_valid && req_ready && req_space == 2'h0 |=> psb_out_valid && !lbx_out_valid)
    else $error("io request not on parallel bus");
  chk_lbx_route: assert property (
    req_valid && req_ready && req_space == 2'h1 && req_addr[31:26] == 6'h00
    |=> lbx_out_valid && !psb_out_valid && {6'h00, lbx_out_addr} == ($past(req_addr) & 32'h03FF_FFFF))
    else $error("low memory request misrouted");
  chk_psb_route: assert property (
    req_valid && req_ready && req_space == 2'h1 && req_addr[31:26] != 6'h00
    |=> psb_out_valid && !lbx_out_valid && psb_out_addr == $past(req_addr))
    else $error("high memory request misrouted");
  chk_out_hold: assert property (
    psb_out_valid && !psb_out_ready |=> psb_out_valid && $stable(psb_out_addr) && $stable(psb_out_data))
    else $error("parallel request changed before completion");
  chk_byte_par: assert property (
    psb_out_valid |-> psb_out_par == {^psb_out_data[31:24], ^psb_out_data[23:16], ^psb_out_data[15:8],
    ^psb_out_data[7:0]})
    else $error("byte parity wrong");
  chk_rd_return: assert property (
    psb_out_valid && psb_out_ready && !psb_out_write |=> req_rsp_valid && req_rdata == $past(psb_out_rdata))
    else $error("read data not returned");
  chk_ack_after: assert property (
    rcv_valid && rcv_ready |=> !rcv_valid && (psb_in_ready || lbx_in_ready))
    else $error("bus handshake did not follow receiver");
  chk_one_winner: assert property (
    lbx_in_ready |-> !(psb_in_ready && psb_in_space != 2'h2))
    else $error("both buses served at once");
endmodule
bind aasi_agent aasi_agent_sva u_sva (.*);
`default_nettype wire

// [dv/aasi_peer.sv]
`default_nettype none
module aasi_peer #(
  parameter int DELAY = 0
) (
  input  wire logic        core_clk, // Clock.
  input  wire logic        rst_b,    // Reset, active low.
  input  wire logic        valid,    // Request from the block.
  output var  logic        ready,    // Completion, one cycle.
  input  wire logic [31:0] addr,     // Request address.
  output var  logic [31:0] rdata     // Read data.
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt;
  // Outside the answer cycle the data toggles so that a stale value is never taken.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ready <= 1'b0;
      rdata <= 32'h0000_0000;
      wait_cnt <= 0;
    end else if (valid && !ready && wait_cnt == DELAY) begin
      ready <= 1'b1;
      rdata <= addr ^ 32'h3C3C_0000;
      wait_cnt <= 0;
    end else begin
      ready <= 1'b0;
      rdata <= ~rdata;
      wait_cnt <= (valid && !ready) ? wait_cnt + 1 : 0;
    end
  end
endmodule
`default_nettype wire

// [dv/tb_agent_address_space_interface.sv]
`default_nettype none
module tb_agent_address_space_interface;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] RK = 32'hA5A5_0000;
  localparam int LIM = 99;
  logic        core_clk, rst_b, req_valid, req_ready, req_write, req_last, req_rsp_valid, psb_out_valid;
  logic        psb_out_ready, psb_out_write, psb_out_last, lbx_out_valid, lbx_out_ready, lbx_out_write;
  logic        lbx_out_last, psb_in_valid, psb_in_ready, psb_in_write, psb_in_first, psb_in_last;
  logic        lbx_in_valid, lbx_in_ready, lbx_in_write, lbx_in_first, rcv_valid, rcv_ready, rcv_write;
  logic        msg_valid, msg_ready, msg_last, msg_err;
  logic [1:0]  req_space, req_width, psb_out_space, psb_out_width, lbx_out_width, psb_in_space;
  logic [1:0]  psb_in_width, lbx_in_width, rcv_space, rcv_width;
  logic [3:0]  psb_out_par, psb_in_par;
  logic [7:0]  my_msg_addr;
  logic [15:0] io_base, io_mask;
  logic [25:0] lbx_out_addr, lbx_in_addr, lbx_mem_base, lbx_mem_mask;
  logic [31:0] req_addr, req_wdata, req_rdata, psb_out_addr, psb_out_data, psb_out_rdata, lbx_out_data;
  logic [31:0] lbx_out_rdata, psb_in_addr, psb_in_data, psb_in_rdata, lbx_in_data, lbx_in_rdata;
  logic [31:0] psb_mem_base, psb_mem_mask, rcv_addr, rcv_wdata, rcv_rdata, msg_data, rcv_log, first_word;
  int          error_cnt = 0, compares = 0, out_cnt = 0, bad_cnt = 0, took, last_cnt = 0;

  always #4 core_clk = ~core_clk;
  aasi_agent u_dut (.*);
  aasi_peer #(.DELAY(0)) u_psb (.core_clk(core_clk), .rst_b(rst_b), .valid(psb_out_valid),
    .ready(psb_out_ready), .addr(psb_out_addr), .rdata(psb_out_rdata));
  aasi_peer #(.DELAY(3)) u_lbx (.core_clk(core_clk), .rst_b(rst_b), .valid(lbx_out_valid),
    .ready(lbx_out_ready), .addr({6'h00, lbx_out_addr}), .rdata(lbx_out_rdata));

  // Receiver stand-in: answers every operation one cycle after it appears.
  always @(posedge core_clk) begin
    rcv_ready <= rcv_valid && !rcv_ready;
    rcv_rdata <= rcv_addr ^ RK;
    if (rcv_valid)
      rcv_log <= rcv_addr;
    out_cnt <= out_cnt + (msg_valid && msg_ready);
    bad_cnt <= bad_cnt + (msg_valid && msg_ready && msg_err);
    last_cnt <= last_cnt + (msg_valid && msg_ready && msg_last);
    if (msg_valid && msg_ready && out_cnt == 0)
      first_word <= msg_data;
  end

  task automatic give_verdict();
    if (error_cnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cut(input int n);
    if (n >= LIM) begin
      error_cnt++;
      give_verdict();
    end
  endtask

  task automatic req_op(input logic [1:0] sp, input logic wr, input logic [31:0] ad, input logic to_lbx);
    int n = 0;
    logic [3:0] fld;
    req_valid <= 1'b1;
    req_space <= sp;
    req_write <= wr;
    req_addr <= ad;
    req_wdata <= ~ad;
    req_width <= 2'h3;
    req_last <= 1'b1;
    do @(posedge core_clk); while (req_ready !== 1'b1 && ++n < LIM);
    cut(n);
    req_valid <= 1'b0;
    n = 0;
    do @(posedge core_clk); while (psb_out_valid !== 1'b1 && lbx_out_valid !== 1'b1 && ++n < LIM);
    cut(n);
    chk(lbx_out_valid, to_lbx);
    chk(to_lbx ? {6'h00, lbx_out_addr} : {psb_out_space, psb_out_addr[29:0]}, {to_lbx ? 2'h0 : sp, ad[29:0]});
    fld = to_lbx ? {lbx_out_write, lbx_out_width, lbx_out_last} : {psb_out_write, psb_out_width, psb_out_last};
    chk(fld, {wr, 2'h3, 1'b1});
    chk(to_lbx ? lbx_out_data : psb_out_data, ~ad);
    n = 0;
    if (!wr) begin
      do @(posedge core_clk); while (req_rsp_valid !== 1'b1 && ++n < LIM);
      cut(n);
      chk(req_rdata, ad ^ 32'h3C3C_0000);
    end
  endtask

  task automatic pin(input logic [1:0] sp, input logic wr, fi, la, input logic [31:0] ad,
                     input logic [1:0] wd, input logic [31:0] dt, input int lim);
    int n = 0;
    psb_in_valid <= 1'b1;
    psb_in_space <= sp;
    psb_in_write <= wr;
    psb_in_first <= fi;
    psb_in_last <= la;
    psb_in_addr <= ad;
    psb_in_width <= wd;
    psb_in_data <= dt;
    psb_in_par <= {^dt[31:24], ^dt[23:16], ^dt[15:8], ^dt[7:0]};
    do @(posedge core_clk); while (psb_in_ready !== 1'b1 && ++n < lim);
    took = (psb_in_ready === 1'b1);
    if (lim == LIM)
      cut(n);
  endtask

  task automatic pkt(input logic [7:0] dst, src, ty, input int words);
    for (int i = 0; i < words; i++)
      pin(2'h2, 1'b1, i == 0, i == words - 1, 32'h0, 2'h3, i == 0 ? {16'h0000, src, dst} :
          (i == 1 ? {24'h00_0000, ty} : i), LIM);
  endtask

  task automatic t_msg_rd();
    int seen = 0;
    req_valid <= 1'b1;
    req_space <= 2'h2;
    req_write <= 1'b0;
    do @(posedge core_clk); while (req_ready !== 1'b1 && ++seen < LIM);
    cut(seen);
    req_valid <= 1'b0;
    seen = 0;
    repeat (4) begin
      @(posedge core_clk);
      seen += (psb_out_valid !== 1'b0) || (req_rsp_valid !== 1'b0);
    end
    chk(seen, 0);
  endtask

  task automatic t_io_seq();
    pin(2'h0, 1'b1, 1'b1, 1'b0, 32'h0000_1238, 2'h3, 32'h1, LIM);
    chk(rcv_log[15:0], 16'h1238);
    pin(2'h0, 1'b1, 1'b0, 1'b0, 32'h0000_123C, 2'h3, 32'h2, LIM);
    chk(rcv_log[15:0], 16'h1238);
    pin(2'h0, 1'b0, 1'b0, 1'b1, 32'h0000_123C, 2'h3, 32'h3, LIM);
    chk(psb_in_rdata[15:0], 16'h1238);
    pin(2'h0, 1'b1, 1'b1, 1'b1, 32'h0000_1248, 2'h3, 32'h4, 10);
    chk(took, 0);
    psb_in_valid <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic t_mem_seq();
    for (int w = 0; w < 4; w++)
      for (int k = 0; k < 3; k++) begin
        pin(2'h1, 1'b1, k == 0, k == 2, 32'h8000_0100, w[1:0], k, LIM);
        chk(rcv_log, 32'h8000_0100 + k * (w == 0 ? 1 : (w == 1 ? 2 : 4)));
        chk({rcv_space, rcv_write, rcv_width, rcv_wdata[7:0]}, {2'h1, 1'b1, w[1:0], k[7:0]});
      end
    psb_in_valid <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic t_arb();
    int n;
    {lbx_in_valid, lbx_in_write, lbx_in_first, lbx_in_addr, lbx_in_width} <= {3'b101, 26'h100_0080, 2'h3};
    pin(2'h1, 1'b0, 1'b1, 1'b1, 32'h8000_0040, 2'h3, 32'h0, 0);
    for (int i = 0; i < 2; i++) begin
      n = 0;
      do @(posedge core_clk); while (psb_in_ready !== 1'b1 && lbx_in_ready !== 1'b1 && ++n < LIM);
      cut(n);
      chk(lbx_in_ready, i == 0);
      chk(rcv_log, psb_in_ready === 1'b1 ? 32'h8000_0040 : 32'h0100_0080);
      chk(psb_in_ready === 1'b1 ? psb_in_rdata : lbx_in_rdata, rcv_log ^ RK);
      if (psb_in_ready === 1'b1)
        psb_in_valid <= 1'b0;
      else
        lbx_in_valid <= 1'b0;
    end
    @(posedge core_clk);
  endtask

  task automatic drain(input int exp_cnt);
    int n = 0;
    psb_in_valid <= 1'b0;
    do @(posedge core_clk); while (msg_valid !== 1'b0 && ++n < LIM);
    cut(n);
    chk(out_cnt, exp_cnt);
  endtask

  task automatic t_msg();
    msg_ready <= 1'b1;
    pkt(8'h21, 8'h05, 8'h00, 3);
    pkt(8'hFF, 8'h05, 8'h01, 2);
    pkt(8'h22, 8'h05, 8'h02, 3);
    pkt(8'h21, 8'hFF, 8'h03, 2);
    pkt(8'h21, 8'h05, 8'h06, 2);
    for (int t = 0; t < 6; t++)
      pkt(8'h21, 8'h05, t[7:0], 2);
    pkt(8'h21, 8'h05, 8'h00, 1);
    pkt(8'h21, 8'h05, 8'h01, 9);
    drain(28);
    chk(bad_cnt, 1);
    chk(first_word, 32'h0000_0521);
    chk(last_cnt, 10);
    msg_ready <= 1'b0;
    repeat (4) pkt(8'h21, 8'h05, 8'h00, 8);
    pin(2'h2, 1'b1, 1'b1, 1'b1, 32'h0, 2'h3, 32'h0000_0521, 10);
    chk(took, 0);
    msg_ready <= 1'b1;
    pin(2'h2, 1'b1, 1'b1, 1'b1, 32'h0, 2'h3, 32'h0000_0521, LIM);
    drain(61);
    chk(last_cnt, 15);
  endtask

  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    {req_valid, req_write, req_last, req_space, req_width, req_addr, req_wdata, msg_ready} = '0;
    {psb_in_valid, psb_in_space, psb_in_write, psb_in_first, psb_in_last, psb_in_addr, psb_in_width} = '0;
    {psb_in_data, psb_in_par, rcv_ready, rcv_rdata} = '0;
    {lbx_in_valid, lbx_in_write, lbx_in_first, lbx_in_addr, lbx_in_width, lbx_in_data} = '0;
    {io_base, io_mask, my_msg_addr} = {16'h1230, 16'hFFF0, 8'h21};
    {psb_mem_base, psb_mem_mask} = {32'h8000_0000, 32'hFF00_0000};
    {lbx_mem_base, lbx_mem_mask} = {26'h100_0000, 26'h300_0000};
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    req_op(2'h0, 1'b1, 32'h0000_1234, 1'b0);
    req_op(2'h0, 1'b0, 32'h0000_0ABC, 1'b0);
    req_op(2'h1, 1'b0, 32'h03FF_FFFC, 1'b1);
    req_op(2'h1, 1'b0, 32'h0400_0000, 1'b0);
    req_op(2'h1, 1'b1, 32'h0000_0010, 1'b1);
    req_op(2'h2, 1'b1, 32'h0000_0021, 1'b0);
    t_msg_rd();
    t_io_seq();
    t_mem_seq();
    t_arb();
    t_msg();
    give_verdict();
  end
endmodule
`default_nettype wire
